// [ccs_defines.vh]
`ifndef CCS_DEFINES_VH
`define CCS_DEFINES_VH
// register indexes; byte address is four times the index
`define CCS_IDX_OPTION 22'h0000C2
`define CCS_IDX_MODE 22'h0F00A0
`define CCS_IDX_RUN 22'h0F00A1
`define CCS_IDX_STAT 22'h0F00A2
`define CCS_IDX_STSEL 22'h0F00A3
`define CCS_IDX_SYSCLK 22'h0F00A4
`define CCS_IDX_SUPPLY 22'h0F00A5
`define CCS_IDX_HDIV 22'h0F00A8
// writable bit masks; other positions read zero, except system clock status bits 7 and 5
`define CCS_MASK_MODE 8'hF7
`define CCS_MASK_RUN 8'hC1
`define CCS_MASK_STSEL 8'h07
`define CCS_MASK_SYSCLK 8'h50
`define CCS_MASK_SUPPLY 8'h90
`define CCS_MASK_HDIV 3'h7
// reset values
`define CCS_RST_MODE 8'h00
`define CCS_RST_RUN 8'hC0
`define CCS_RST_STSEL 8'h07
`define CCS_RST_SYSCLK 8'h00
`define CCS_RST_SUPPLY 8'h00
// field positions
`define CCS_MODE_EXTMAIN 7
`define CCS_MODE_MAINSEL 6
`define CCS_MODE_EXTSUB 5
`define CCS_MODE_SUBSEL 4
`define CCS_MODE_DRV_HI 2
`define CCS_MODE_DRV_LO 1
`define CCS_MODE_HIGAIN 0
`define CCS_RUN_MAINSTOP 7
`define CCS_RUN_SUBSTOP 6
`define CCS_RUN_INTSTOP 0
`define CCS_SYS_SUBSTAT 7
`define CCS_SYS_SUBREQ 6
`define CCS_SYS_MAINSTAT 5
`define CCS_SYS_MAINREQ 4
`define CCS_SUPPLY_RTCLP 7
`define CCS_OPT_F3 3
// source codes of the clock multiplexer
`define CCS_SRC_HOCO 2'h0
`define CCS_SRC_MAIN 2'h1
`define CCS_SRC_SUB 2'h2
// flash speed mode codes
`define CCS_FLASH_LOWV 2'h0
`define CCS_FLASH_BAD 2'h1
`define CCS_FLASH_LOWSPD 2'h2
`define CCS_FLASH_HISPD 2'h3
// divider code limits
`define CCS_DIV_MAX_LO 3'h3
`define CCS_DIV_MAX_HI 3'h5
// stabilization counter width, main oscillator ticks up to 2^18
`define CCS_STAB_W 19
`endif

// [ccs_clock_select.v]
// Our own choice: the APB slave port.
`timescale 1ns/1ns
// Functional notes
// - reset always returns clock to internal oscillator
// - config byte low nibble sets base frequency
// - config bits 7:6 give flash speed mode
// - divider field sets internal oscillator output
// - subsystem select enables 32 kHz path, drive mode
// - stabilization select sets main crystal wait time
// - main stop bit clear starts main crystal
// - status counter sets bits from bit 7 downward
// - main clock select bit switches to main clock
// - low-power bit limits subclock users in standby
// - sub stop bit clear starts 32 kHz oscillator
// - subsystem select bit switches clock to subclock
// - internal oscillator stop bit, runs after reset
// - mode control register written once after reset
`include "ccs_defines.vh"
module ccs_clock_select #(
  parameter ADDR_W = 24
) (
  input wire core_clk, // system clock, 25 MHz
  input wire rst_n, // synchronous reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb write
  input wire [ADDR_W-1:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  input wire [3:0] pstrb, // apb byte strobes
  output wire pready, // apb ready
  output wire pslverr, // apb error on unmapped address
  output wire [31:0] prdata, // apb read data
  input wire [7:0] flash_config_byte, // nonvolatile configuration byte
  input wire hoco_tick, // internal oscillator raw pulse
  input wire main_crystal_tick, // main crystal pulse
  input wire ext_main_tick, // external main clock pulse
  input wire sub_crystal_tick, // 32 kHz crystal pulse
  input wire ext_sub_tick, // external sub clock pulse
  input wire standby, // stop or sub-halt mode active
  output wire fclk_en, // cpu and peripheral clock pulse
  output wire main_crystal_run, // main crystal amplifier on
  output wire main_osc_high_gain, // main amplifier high gain
  output wire sub_crystal_run, // 32 kHz amplifier on
  output wire [1:0] sub_osc_drive_mode, // 32 kHz drive mode
  output wire hoco_run, // internal oscillator on
  output wire stab_done, // selected stabilization time reached
  output wire [1:0] flash_speed_mode, // flash operating mode
  output wire config_error, // prohibited configuration code
  output wire sub_clk_rtc_en, // subclock pulse for rtc, timer, lcd
  output wire sub_clk_other_en // subclock pulse for other users
);

  // prohibited divider codes depend on the top frequency bit
  function div_ok;
    input f3;
    input [2:0] div;
    begin
      if (f3)
        div_ok = (div != 3'h0) && (div <= `CCS_DIV_MAX_HI);
      else
        div_ok = (div <= `CCS_DIV_MAX_LO);
    end
  endfunction

  // address match for one register index, used for writes and reads
  function hit;
    input [ADDR_W-3:0] idx;
    input [21:0] target;
    begin
      hit = (idx == target[ADDR_W-3:0]);
    end
  endfunction

  reg [7:0] mode_r;
  reg mode_done_r;
  reg [7:0] run_r;
  reg [7:0] stsel_r;
  reg [7:0] sysclk_r;
  reg [7:0] supply_r;
  reg [2:0] hdiv_r;
  reg [7:0] opt_r;
  reg opt_loaded_r;
  reg [1:0] cur_src_r;
  reg [5:0] div_cnt_r;
  reg [`CCS_STAB_W-1:0] stab_cnt_r;
  reg [31:0] prdata_r;
  reg [1:0] target_src;
  reg [7:0] rd_val;
  reg map_ok;
  reg cur_tick;
  reg new_tick;
  wire [ADDR_W-3:0] idx = paddr[ADDR_W-1:2];
  wire wr_acc = psel && penable && pwrite && pstrb[0];
  wire setup = psel && !penable;
  wire [7:0] stab_status;
  wire hoco_out;
  wire main_tick;
  wire sub_tick;
  wire [5:0] div_top;

  // config byte is sampled once, in the cycle after reset release
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      opt_r <= 8'h00;
      opt_loaded_r <= 1'b0;
    end
    else if (!opt_loaded_r)
    begin
      opt_r <= flash_config_byte;
      opt_loaded_r <= 1'b1;
    end
  end

  assign flash_speed_mode = opt_r[7:6];
  assign config_error = opt_loaded_r && ((opt_r[7:6] == `CCS_FLASH_BAD) ||
    !div_ok(opt_r[`CCS_OPT_F3], opt_r[2:0]));

  // mode control takes one write with all four strobes per reset, later ones dropped
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      mode_r <= `CCS_RST_MODE;
      mode_done_r <= 1'b0;
    end
    else if (wr_acc && hit(idx, `CCS_IDX_MODE) && !mode_done_r && (pstrb == 4'hF))
    begin
      mode_r <= pwdata[7:0] & `CCS_MASK_MODE;
      mode_done_r <= 1'b1;
    end
  end

  // plain control registers
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      run_r <= `CCS_RST_RUN;
      stsel_r <= `CCS_RST_STSEL;
      sysclk_r <= `CCS_RST_SYSCLK;
      supply_r <= `CCS_RST_SUPPLY;
    end
    else if (wr_acc)
    begin
      if (hit(idx, `CCS_IDX_RUN))
        run_r <= pwdata[7:0] & `CCS_MASK_RUN;
      if (hit(idx, `CCS_IDX_STSEL))
        stsel_r <= pwdata[7:0] & `CCS_MASK_STSEL;
      if (hit(idx, `CCS_IDX_SYSCLK))
        sysclk_r <= pwdata[7:0] & `CCS_MASK_SYSCLK;
      if (hit(idx, `CCS_IDX_SUPPLY))
        supply_r <= pwdata[7:0] & `CCS_MASK_SUPPLY;
    end
  end

  // divider: loaded from config at release, prohibited writes dropped
  always @(posedge core_clk)
  begin
    if (!rst_n)
      hdiv_r <= 3'h0;
    else if (!opt_loaded_r)
      hdiv_r <= flash_config_byte[2:0];
    else if (wr_acc && hit(idx, `CCS_IDX_HDIV) &&
      div_ok(opt_r[`CCS_OPT_F3], pwdata[2:0]))
      hdiv_r <= pwdata[2:0] & `CCS_MASK_HDIV;
  end

  // oscillator enables and amplifier settings
  assign hoco_run = !run_r[`CCS_RUN_INTSTOP];
  assign main_crystal_run = !run_r[`CCS_RUN_MAINSTOP] && mode_r[`CCS_MODE_MAINSEL] &&
    !mode_r[`CCS_MODE_EXTMAIN];
  assign main_osc_high_gain = mode_r[`CCS_MODE_HIGAIN];
  assign sub_crystal_run = !run_r[`CCS_RUN_SUBSTOP] && mode_r[`CCS_MODE_SUBSEL] &&
    !mode_r[`CCS_MODE_EXTSUB];
  assign sub_osc_drive_mode = mode_r[`CCS_MODE_DRV_HI:`CCS_MODE_DRV_LO];

  // source pulses; an external clock needs the same stop bit cleared
  assign main_tick = !run_r[`CCS_RUN_MAINSTOP] && mode_r[`CCS_MODE_MAINSEL] &&
    (mode_r[`CCS_MODE_EXTMAIN] ? ext_main_tick : main_crystal_tick);
  assign sub_tick = !run_r[`CCS_RUN_SUBSTOP] && mode_r[`CCS_MODE_SUBSEL] &&
    (mode_r[`CCS_MODE_EXTSUB] ? ext_sub_tick : sub_crystal_tick);

  // internal oscillator divided by 2^code, top rate set by config bit 3
  assign div_top = (6'h01 << hdiv_r) - 6'h01;
  always @(posedge core_clk)
  begin
    if (!rst_n)
      div_cnt_r <= 6'h00;
    else if (hoco_run && hoco_tick)
      div_cnt_r <= (div_cnt_r >= div_top) ? 6'h00 : div_cnt_r + 6'h01;
  end
  assign hoco_out = hoco_run && hoco_tick && (div_cnt_r >= div_top);

  // stabilization counter restarts whenever the crystal is stopped;
  // an external main clock is marked settled at once
  always @(posedge core_clk)
  begin
    if (!rst_n || !main_crystal_run)
      stab_cnt_r <= {`CCS_STAB_W{1'b0}};
    else if (main_crystal_tick && !stab_cnt_r[`CCS_STAB_W-1])
      stab_cnt_r <= stab_cnt_r + {{(`CCS_STAB_W-1){1'b0}}, 1'b1};
  end

  // thermometer status: 2^8,2^9,2^10,2^11,2^13,2^15,2^17,2^18 ticks
  assign stab_status[7] = |stab_cnt_r[`CCS_STAB_W-1:8];
  assign stab_status[6] = |stab_cnt_r[`CCS_STAB_W-1:9];
  assign stab_status[5] = |stab_cnt_r[`CCS_STAB_W-1:10];
  assign stab_status[4] = |stab_cnt_r[`CCS_STAB_W-1:11];
  assign stab_status[3] = |stab_cnt_r[`CCS_STAB_W-1:13];
  assign stab_status[2] = |stab_cnt_r[`CCS_STAB_W-1:15];
  assign stab_status[1] = |stab_cnt_r[`CCS_STAB_W-1:17];
  assign stab_status[0] = stab_cnt_r[`CCS_STAB_W-1];
  // code k waits for status bit 7-k
  assign stab_done = stab_status[3'h7 - stsel_r[2:0]] ||
    (mode_r[`CCS_MODE_EXTMAIN] && !run_r[`CCS_RUN_MAINSTOP]);

  // requested source; subsystem select outranks main select
  always @*
  begin
    if (sysclk_r[`CCS_SYS_SUBREQ])
      target_src = `CCS_SRC_SUB;
    else if (sysclk_r[`CCS_SYS_MAINREQ])
      target_src = `CCS_SRC_MAIN;
    else
      target_src = `CCS_SRC_HOCO;
  end

  // pulse of current source and of requested source
  always @*
  begin
    case (cur_src_r)
      `CCS_SRC_MAIN: cur_tick = main_tick;
      `CCS_SRC_SUB: cur_tick = sub_tick;
      default: cur_tick = hoco_out;
    endcase
    case (target_src)
      `CCS_SRC_MAIN: new_tick = main_tick;
      `CCS_SRC_SUB: new_tick = sub_tick;
      default: new_tick = hoco_out;
    endcase
  end

  // switch only right after the old source ends a period, so no pulse is
  // cut short; a stopped old source would hang the switch, so its enable
  // falling releases it too. new_tick is unused on purpose: waiting for it
  // would add a cycle with no benefit for a pulse-style clock
  always @(posedge core_clk)
  begin
    if (!rst_n)
      cur_src_r <= `CCS_SRC_HOCO;
    else if (target_src != cur_src_r && (cur_tick ||
      (cur_src_r == `CCS_SRC_HOCO && !hoco_run) ||
      (cur_src_r == `CCS_SRC_MAIN && run_r[`CCS_RUN_MAINSTOP]) ||
      (cur_src_r == `CCS_SRC_SUB && run_r[`CCS_RUN_SUBSTOP])))
      cur_src_r <= target_src;
  end

  // the switching cycle passes the old pulse, never a partial one
  assign fclk_en = cur_tick;

  // low-power bit withholds the subclock from other users in standby
  assign sub_clk_rtc_en = sub_tick;
  assign sub_clk_other_en = sub_tick && !(supply_r[`CCS_SUPPLY_RTCLP] && standby);

  // read mux; status bits of the select register show the live source
  always @*
  begin
    map_ok = 1'b1;
    rd_val = 8'h00;
    if (hit(idx, `CCS_IDX_OPTION))
      rd_val = opt_r;
    else if (hit(idx, `CCS_IDX_MODE))
      rd_val = mode_r;
    else if (hit(idx, `CCS_IDX_RUN))
      rd_val = run_r;
    else if (hit(idx, `CCS_IDX_STAT))
      rd_val = stab_status;
    else if (hit(idx, `CCS_IDX_STSEL))
      rd_val = stsel_r;
    else if (hit(idx, `CCS_IDX_SYSCLK))
      rd_val = sysclk_r | {cur_src_r == `CCS_SRC_SUB, 1'b0, cur_src_r == `CCS_SRC_MAIN, 5'h00};
    else if (hit(idx, `CCS_IDX_SUPPLY))
      rd_val = supply_r;
    else if (hit(idx, `CCS_IDX_HDIV))
      rd_val = {5'h00, hdiv_r};
    else
      map_ok = 1'b0;
  end

  // read data captured in the setup cycle, held through the access
  always @(posedge core_clk)
  begin
    if (!rst_n)
      prdata_r <= 32'h00000000;
    else if (setup)
      prdata_r <= {24'h000000, rd_val};
  end

  // zero-wait slave
  assign pready = 1'b1;
  assign pslverr = psel && penable && !map_ok;
  assign prdata = prdata_r;

endmodule // ccs_clock_select

// [ccs_clock_select_assertions.sv]
`timescale 1ns/1ns
module ccs_clock_select_chk (
  input wire core_clk, // clock
  input wire rst_n, // sync reset
  input wire psel, // apb select
  input wire penable, // apb access
  input wire pslverr, // apb error
  input wire [31:0] prdata, // read data
  input wire hoco_tick, // hoco pulse
  input wire main_crystal_tick, // crystal pulse
  input wire ext_main_tick, // ext main pulse
  input wire sub_crystal_tick, // 32 kHz pulse
  input wire ext_sub_tick, // ext sub pulse
  input wire fclk_en, // cpu clock pulse
  input wire sub_clk_rtc_en, // rtc subclock
  input wire sub_clk_other_en, // other subclock
  input wire hoco_run, // hoco on
  input wire main_crystal_run, // crystal on
  input wire [1:0] flash_speed_mode, // flash mode
  input wire config_error // bad config
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // apb phases
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_err_in_access: assert property (pslverr |-> s_access)
    else $error("pslverr outside access phase");
  a_release_hoco: assert property ($rose(rst_n) |-> hoco_run && !main_crystal_run)
    else $error("reset release not on hoco");
  a_upper_zero: assert property (prdata[31:8] == 24'h0)
    else $error("prdata upper bits not zero");
  a_fclk_from_tick: assert property (fclk_en |-> hoco_tick || main_crystal_tick || ext_main_tick
    || sub_crystal_tick || ext_sub_tick)
    else $error("fclk pulse without source pulse");
  a_rtc_from_sub: assert property (sub_clk_rtc_en |-> sub_crystal_tick || ext_sub_tick)
    else $error("rtc pulse without sub pulse");
  a_other_masked: assert property (sub_clk_other_en |-> sub_clk_rtc_en)
    else $error("other subclock without rtc subclock");
  a_mode_error: assert property (flash_speed_mode == 2'h1 |-> config_error)
    else $error("prohibited flash mode not flagged");
  a_mode_held: assert property ($past(rst_n) && $past(rst_n, 2) |-> $stable(flash_speed_mode))
    else $error("flash mode changed after load");
  c_transfer: cover property (s_setup ##1 s_access);
endmodule // ccs_clock_select_chk
bind ccs_clock_select ccs_clock_select_chk u_chk (.core_clk, .rst_n, .psel, .penable, .pslverr, .prdata,
  .hoco_tick, .main_crystal_tick, .ext_main_tick, .sub_crystal_tick, .ext_sub_tick, .fclk_en,
  .sub_clk_rtc_en, .sub_clk_other_en, .hoco_run, .main_crystal_run, .flash_speed_mode, .config_error);

// [ccs_clock_select_bench.sv]
`timescale 1ns/1ns
`include "ccs_defines.vh"
module ccs_clock_select_bench;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [23:0] paddr = 24'h0;
  reg [31:0] pwdata = 32'h0;
  reg hoco_tick = 1'b0;
  reg main_crystal_tick = 1'b0;
  reg sub_crystal_tick = 1'b0;
  reg standby = 1'b0;
  reg [7:0] cfg = 8'hE0;
  reg ext_tick = 1'b0;
  reg [5:0] tk = 6'h00;
  reg [31:0] rd;
  reg err;
  integer n_fail = 0;
  integer tests_run = 0;
  integer nf, nr, no, i;
  wire [31:0] prdata;
  wire [1:0] drv, fsm;
  wire pready, pslverr, fclk_en, mrun, hg, srun, hrun, sdone, cerr, rtc, oth;
  ccs_clock_select u_ccs_clock_select (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .flash_config_byte(cfg), .hoco_tick(hoco_tick), .main_crystal_tick(main_crystal_tick),
    .ext_main_tick(ext_tick), .sub_crystal_tick(sub_crystal_tick), .ext_sub_tick(1'b0), .standby(standby),
    .fclk_en(fclk_en), .main_crystal_run(mrun), .main_osc_high_gain(hg), .sub_crystal_run(srun),
    .sub_osc_drive_mode(drv), .hoco_run(hrun), .stab_done(sdone), .flash_speed_mode(fsm),
    .config_error(cerr), .sub_clk_rtc_en(rtc), .sub_clk_other_en(oth));
  always #20 core_clk = ~core_clk;
  // pulses with periods 2, 3, 8, 4; mod-48 so every window is exact
  always @(posedge core_clk)
  begin
    tk <= (tk == 6'h2F) ? 6'h00 : tk + 6'h01;
    hoco_tick <= tk[0];
    main_crystal_tick <= (tk % 6'h03) == 6'h00;
    sub_crystal_tick <= tk[2:0] == 3'h7;
    ext_tick <= tk[1:0] == 2'h3;
  end
  task close_out;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [8*5-1:0] nm, input [31:0] ex, input [31:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== ex)
      begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0s exp %h got %h", nm, ex, got);
      end
    end
  endtask
  // one apb transfer; an idle edge always precedes setup
  task apb(input w, input [21:0] ix, input [7:0] d);
    integer k;
    begin
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {ix, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      @(posedge core_clk);
      while (pready !== 1'b1 && k < 9)
      begin
        @(posedge core_clk);
        k = k + 1;
      end
      if (k == 9)
      begin
        n_fail = n_fail + 1;
        close_out;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rc(input [8*5-1:0] nm, input [21:0] ix, input [7:0] ex);
    begin
      apb(1'b0, ix, 8'h00);
      chk(nm, {24'h0, ex}, rd);
    end
  endtask
  // count clock pulses over 48 cycles, sampled mid-cycle
  task cnt;
    begin
      nf = 0;
      nr = 0;
      no = 0;
      repeat (48)
      begin
        @(negedge core_clk);
        nf = nf + (fclk_en === 1'b1);
        nr = nr + (rtc === 1'b1);
        no = no + (oth === 1'b1);
      end
    end
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    rc("mctl", `CCS_IDX_MODE, 8'h00);
    rc("rctl", `CCS_IDX_RUN, 8'hC0);
    rc("stsel", `CCS_IDX_STSEL, 8'h07);
    rc("sysck", `CCS_IDX_SYSCLK, 8'h00);
    rc("supl", `CCS_IDX_SUPPLY, 8'h00);
    rc("hdiv", `CCS_IDX_HDIV, 8'h00);
    rc("opt", `CCS_IDX_OPTION, 8'hE0);
    chk("mode", 32'h3, {30'h0, fsm});
    chk("cerr", 32'h0, {31'h0, cerr});
    cnt;
    chk("fclk", 32'd24, nf);
    apb(1'b1, `CCS_IDX_RUN, 8'hFF);
    rc("rctl", `CCS_IDX_RUN, 8'hC1);
    chk("hrun", 32'h0, {31'h0, hrun});
    apb(1'b1, `CCS_IDX_RUN, 8'hC0);
    apb(1'b1, `CCS_IDX_HDIV, 8'hFB);
    apb(1'b1, `CCS_IDX_HDIV, 8'h04);
    rc("hdiv", `CCS_IDX_HDIV, 8'h03);
    cnt;
    chk("fclk", 32'd3, nf);
    // reserved bit 3 set on purpose, then a second write that must not land
    apb(1'b1, `CCS_IDX_MODE, 8'h5C);
    apb(1'b1, `CCS_IDX_MODE, 8'h00);
    rc("mctl", `CCS_IDX_MODE, 8'h54);
    chk("drv", 32'h2, {30'h0, drv});
    chk("gain", 32'h0, {31'h0, hg});
    apb(1'b1, `CCS_IDX_STSEL, 8'h00);
    chk("mrun", 32'h0, {31'h0, mrun});
    apb(1'b1, `CCS_IDX_RUN, 8'h40);
    @(negedge core_clk);
    chk("mrun", 32'h1, {31'h0, mrun});
    rd = 32'h0;
    i = 0;
    while (rd[7] !== 1'b1 && i < 400)
    begin
      apb(1'b0, `CCS_IDX_STAT, 8'h00);
      i = i + 1;
    end
    chk("stat", 32'h80, rd);
    @(negedge core_clk);
    chk("sdone", 32'h1, {31'h0, sdone});
    apb(1'b1, `CCS_IDX_SYSCLK, 8'h10);
    repeat (40) @(posedge core_clk);
    rc("sysck", `CCS_IDX_SYSCLK, 8'h30);
    cnt;
    chk("fclk", 32'd16, nf);
    apb(1'b1, `CCS_IDX_SUPPLY, 8'h80);
    apb(1'b1, `CCS_IDX_RUN, 8'h00);
    @(negedge core_clk);
    chk("srun", 32'h1, {31'h0, srun});
    repeat (50) @(posedge core_clk);
    apb(1'b1, `CCS_IDX_SYSCLK, 8'h50);
    repeat (40) @(posedge core_clk);
    apb(1'b0, `CCS_IDX_SYSCLK, 8'h00);
    chk("sysck", 32'hC0, rd & 32'hC0);
    cnt;
    chk("fclk", 32'd6, nf);
    chk("oth", 32'd6, no);
    standby <= 1'b1;
    cnt;
    chk("rtc", 32'd6, nr);
    chk("oth", 32'd0, no);
    @(posedge core_clk);
    rst_n <= 1'b0;
    // prohibited flash mode code, picked up at the next release
    cfg <= 8'h40;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    rc("sysck", `CCS_IDX_SYSCLK, 8'h00);
    chk("fmode", 32'h1, {30'h0, fsm});
    chk("cerr", 32'h1, {31'h0, cerr});
    cnt;
    chk("fclk", 32'd24, nf);
    // external main clock: selectable with no settling wait
    apb(1'b1, `CCS_IDX_MODE, 8'hC0);
    apb(1'b1, `CCS_IDX_RUN, 8'h40);
    @(negedge core_clk);
    chk("sdone", 32'h1, {31'h0, sdone});
    chk("mrun", 32'h0, {31'h0, mrun});
    apb(1'b1, `CCS_IDX_SYSCLK, 8'h10);
    repeat (40) @(posedge core_clk);
    cnt;
    chk("fclk", 32'd12, nf);
    apb(1'b0, 22'h000100, 8'h00);
    chk("err", 32'h1, {31'h0, err});
    close_out;
  end
endmodule // ccs_clock_select_bench
